// File: cap_assertions.sv
`timescale 1ns/1ps
module cap_assertions (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic selftest_active,
  input wire logic cpu_addr_hold,
  input wire logic mem_side_hold_mirror,
  input wire logic ext_inquire_strobe,
  input wire logic cpu_addr_strobe,
  input wire logic ctrl_addr_strobe_copy,
  input wire cap_pkg::cap_bt_t branch_trace_bits,
  input wire cap_pkg::cap_sram_addr_t sram_addr,
  input wire cap_pkg::cap_addr_t addr,
  input wire logic line_addr_parity,
  input wire logic proc_addr_oe,
  input wire logic proc_par_oe,
  input wire logic ctrl_addr_oe,
  input wire logic ctrl_par_oe
);
  import cap_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // =====================================================
  // Held inquire steps
  sequence s_held;
    cpu_addr_hold && ctrl_par_oe;
  endsequence
  sequence s_inq_tail;
    s_held ##1 !ext_inquire_strobe ##0 s_held;
  endsequence

  a_hold_before_inq: assert property (ext_inquire_strobe |-> $past(cpu_addr_hold, 2)) else $error("no hold before inquire");
  a_inq_held_run: assert property (ext_inquire_strobe |-> s_inq_tail) else $error("inquire outside hold");
  a_proc_floats: assert property (cpu_addr_hold |-> !proc_addr_oe && !proc_par_oe) else $error("proc drives in hold");
  a_ctrl_drives: assert property (cpu_addr_hold |-> ctrl_addr_oe && ctrl_par_oe) else $error("ctrl idle in hold");
  a_proc_owns_par: assert property (!cpu_addr_hold |-> proc_par_oe && !ctrl_par_oe) else $error("parity owner wrong");
  a_parity_even: assert property (line_addr_parity == ^addr[31:5]) else $error("parity wrong");
  a_inq_par_valid: assert property ($rose(ext_inquire_strobe) |-> line_addr_parity == ^addr[31:5]) else $error("inquire parity");
  a_mirror_follow: assert property (!selftest_active [*2] |-> mem_side_hold_mirror == cpu_addr_hold) else $error("mirror");
  a_strobe_copy: assert property (cpu_addr_strobe == ctrl_addr_strobe_copy) else $error("strobe copy differs");
  a_trace_low: assert property (branch_trace_bits == 4'h0) else $error("trace bits set");
  a_sram_map: assert property (sram_addr == {addr[17:3], 1'b0}) else $error("sram address map");
endmodule

// File: cap_ctrl_end.sv
`timescale 1ns/1ps
module cap_ctrl_end #(
  parameter int DRIVE_CYCLES = cap_pkg::DRIVE_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire cap_pkg::cap_kind_e req_kind,
  input wire cap_pkg::cap_addr_t req_addr,
  output logic req_ready,
  output logic req_done,
  input wire logic snoop_wb_active,
  input wire logic repl_wb_active,
  input wire logic init_active,
  input wire logic selftest_active,
  input wire logic cyc_next_addr,
  input wire logic cyc_burst_ready,
  output logic cyc_valid,
  output cap_pkg::cap_addr_t cyc_addr,
  output logic cyc_parity,
  output logic hold_active,
  cap_if.ctrl bus
);
  import cap_pkg::*;

  // =====================================================
  // State
  cap_cst_e state_r;
  cap_cst_e state_nxt;
  cap_kind_e kind_r;
  cap_kind_e kind_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  cap_addr_t addr_r;
  cap_addr_t addr_nxt;
  logic par_r;
  logic par_nxt;
  logic inq_r;
  logic inq_nxt;
  logic done_r;
  logic done_nxt;

  // =====================================================
  // Hold request and memory-side mirror
  logic hold_r;
  logic hold_nxt;
  logic mirror_r;
  logic mirror_nxt;
  logic side_hold;

  // =====================================================
  // Processor cycle capture
  logic cyc_valid_r;
  logic cyc_valid_nxt;
  cap_addr_t cyc_addr_r;
  cap_addr_t cyc_addr_nxt;
  logic cyc_par_r;
  logic cyc_par_nxt;
  logic phase_open_r;
  logic phase_open_nxt;
  logic phase_busy;

  // =====================================================
  // Held-cycle sequencer
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    par_nxt = par_r;
    inq_nxt = 1'b0;
    done_nxt = 1'b0;
    case (state_r)
      CST_IDLE: begin
        if (req_valid && !phase_busy) begin
          kind_nxt = req_kind;
          addr_nxt = req_addr;
          // Parity ready before the strobe clock
          par_nxt = cap_line_par(req_addr);
          state_nxt = CST_SETTLE;
        end
      end
      CST_SETTLE: begin
        // Hold has reached the processor; bus is ours
        state_nxt = CST_STROBE;
      end
      CST_STROBE: begin
        // Snoop-type cycles get the inquire strobe
        if (kind_r == KIND_INQUIRE || kind_r == KIND_BACKINV) begin
          inq_nxt = 1'b1;
        end
        cnt_nxt = 4'(DRIVE_CYCLES);
        state_nxt = CST_DRIVE;
      end
      CST_DRIVE: begin
        if (cnt_r <= CNT_ONE) begin
          cnt_nxt = CNT_ZERO;
          done_nxt = 1'b1;
          state_nxt = CST_IDLE;
        end else begin
          cnt_nxt = cnt_r - CNT_ONE;
        end
      end
      default: begin
        state_nxt = CST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= CST_IDLE;
      kind_r <= KIND_INQUIRE;
      cnt_r <= CNT_ZERO;
      addr_r <= '0;
      par_r <= 1'b0;
      inq_r <= 1'b0;
      done_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      par_r <= par_nxt;
      inq_r <= inq_nxt;
      done_r <= done_nxt;
    end
  end

  // =====================================================
  // Hold generation
  assign side_hold = snoop_wb_active || repl_wb_active || init_active || selftest_active;

  always_comb begin
    hold_nxt = (state_nxt != CST_IDLE) || side_hold;
    mirror_nxt = selftest_active ? 1'b0 : hold_nxt;
  end

  // Reset value keeps the hold up while in reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hold_r <= HOLD_RST;
      mirror_r <= MIRROR_RST;
    end else if (clk_en) begin
      hold_r <= hold_nxt;
      mirror_r <= mirror_nxt;
    end
  end

  // =====================================================
  // Processor cycle capture while parity is an input
  always_comb begin
    cyc_valid_nxt = 1'b0;
    cyc_addr_nxt = cyc_addr_r;
    cyc_par_nxt = cyc_par_r;
    phase_open_nxt = phase_open_r;
    if (phase_open_r && (bus.next_addr_req || bus.burst_ready)) begin
      phase_open_nxt = 1'b0;
    end
    if (bus.ctrl_addr_strobe_copy && !hold_r) begin
      cyc_valid_nxt = 1'b1;
      cyc_addr_nxt = bus.addr;
      cyc_par_nxt = bus.line_addr_parity;
      phase_open_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cyc_valid_r <= 1'b0;
      cyc_addr_r <= '0;
      cyc_par_r <= 1'b0;
      phase_open_r <= 1'b0;
    end else if (clk_en) begin
      cyc_valid_r <= cyc_valid_nxt;
      cyc_addr_r <= cyc_addr_nxt;
      cyc_par_r <= cyc_par_nxt;
      phase_open_r <= phase_open_nxt;
    end
  end

  // =====================================================
  // Processor address phase guard
  // Taking the bus now would cut the parity window short
  assign phase_busy = phase_open_r || (bus.ctrl_addr_strobe_copy && !hold_r);

  // =====================================================
  // Pins
  assign bus.cpu_addr_hold = hold_r;
  assign bus.mem_side_hold_mirror = mirror_r;
  assign bus.ext_inquire_strobe = inq_r;
  assign bus.ctrl_addr_o = addr_r;
  assign bus.ctrl_addr_oe = hold_r;
  assign bus.ctrl_par_o = par_r;
  assign bus.ctrl_par_oe = hold_r;
  assign bus.next_addr_req = cyc_next_addr;
  assign bus.burst_ready = cyc_burst_ready;

  // =====================================================
  // User side
  assign req_ready = (state_r == CST_IDLE) && !phase_busy;
  assign req_done = done_r;
  assign cyc_valid = cyc_valid_r;
  assign cyc_addr = cyc_addr_r;
  assign cyc_parity = cyc_par_r;
  assign hold_active = hold_r;

endmodule

// File: cap_if.sv
`timescale 1ns/1ps
interface cap_if;
  import cap_pkg::*;

  logic cpu_addr_hold;
  logic mem_side_hold_mirror;
  logic ext_inquire_strobe;
  logic next_addr_req;
  logic burst_ready;
  logic cpu_addr_strobe;
  logic ctrl_addr_strobe_copy;
  cap_bt_t branch_trace_bits;
  cap_sram_addr_t sram_addr;
  cap_addr_t proc_addr_o;
  logic proc_addr_oe;
  cap_addr_t ctrl_addr_o;
  logic ctrl_addr_oe;
  logic proc_par_o;
  logic proc_par_oe;
  logic ctrl_par_o;
  logic ctrl_par_oe;
  cap_addr_t addr;
  logic line_addr_parity;

  // =====================================================
  // Shared wire levels; undriven reads as zero
  assign addr = ctrl_addr_oe ? ctrl_addr_o : (proc_addr_oe ? proc_addr_o : '0);
  assign line_addr_parity = ctrl_par_oe ? ctrl_par_o : (proc_par_oe ? proc_par_o : 1'b0);

  modport ctrl (
    output cpu_addr_hold, mem_side_hold_mirror, ext_inquire_strobe,
    output next_addr_req, burst_ready, ctrl_addr_o, ctrl_addr_oe, ctrl_par_o, ctrl_par_oe,
    input ctrl_addr_strobe_copy, branch_trace_bits, addr, line_addr_parity
  );

  modport proc (
    output cpu_addr_strobe, ctrl_addr_strobe_copy, branch_trace_bits, sram_addr,
    output proc_addr_o, proc_addr_oe, proc_par_o, proc_par_oe,
    input cpu_addr_hold, ext_inquire_strobe, next_addr_req, burst_ready, addr, line_addr_parity
  );

endinterface

// File: cap_pkg.sv
// Summary of operation
// - Raise address hold for inquire, invalidate, flush, sync
// - Processor floats address bus during hold
// - Controller drives address and parity during hold
// - Hold also during writebacks, reset, init, selftest
// - Memory-side mirror follows hold except selftest
// - Parity covers line address bits 31 to 5
// - Parity driven by processor unless hold high
// - Processor parity valid strobe to next/ready; a side hold, or a held request taken on the strobe edge, still floats it
// - Parity valid in the inquire strobe clock
// - Branch trace bits held low
// - SRAM address 15:1 from 17:3, bit 0 low
// - Strobe copy identical to address strobe
package cap_pkg;

  // =====================================================
  // Address layout
  localparam int ADDR_HI = 31;
  localparam int ADDR_LO = 3;
  localparam int LINE_LO = 5;
  localparam int SRAM_W = 16;
  localparam int SRAM_CPU_HI = 17;
  localparam int BT_W = 4;

  typedef logic [ADDR_HI:ADDR_LO] cap_addr_t;
  typedef logic [SRAM_W-1:0] cap_sram_addr_t;
  typedef logic [BT_W-1:0] cap_bt_t;

  // =====================================================
  // Reset values and timing
  localparam logic HOLD_RST = 1'b1;
  localparam logic MIRROR_RST = 1'b1;
  localparam logic SRAM_A0 = 1'b0;
  localparam cap_bt_t BT_IDLE = 4'h0;
  localparam int DRIVE_CYC = 2;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // =====================================================
  // Kinds of held cycle and state codes
  typedef enum logic [1:0] {
    KIND_INQUIRE = 2'h0,
    KIND_BACKINV = 2'h1,
    KIND_FLUSH = 2'h2,
    KIND_SYNC = 2'h3
  } cap_kind_e;

  typedef enum logic [3:0] {
    CST_IDLE = 4'h1,
    CST_SETTLE = 4'h2,
    CST_STROBE = 4'h4,
    CST_DRIVE = 4'h8
  } cap_cst_e;

  typedef enum logic [2:0] {
    PST_IDLE = 3'h1,
    PST_ADDR = 3'h2,
    PST_WAIT = 3'h4
  } cap_pst_e;

  // =====================================================
  // Even parity over the line address
  function automatic logic cap_line_par(input cap_addr_t a);
    return ^a[ADDR_HI:LINE_LO];
  endfunction

endpackage

// File: cap_proc_end.sv
`timescale 1ns/1ps
module cap_proc_end (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic cyc_req_valid,
  input wire cap_pkg::cap_addr_t cyc_req_addr,
  output logic cyc_req_ready,
  output logic cyc_done,
  output logic snoop_valid,
  output cap_pkg::cap_addr_t snoop_addr,
  output logic snoop_parity,
  cap_if.proc bus
);
  import cap_pkg::*;

  cap_pst_e state_r;
  cap_pst_e state_nxt;
  cap_addr_t addr_r;
  cap_addr_t addr_nxt;
  logic par_r;
  logic par_nxt;
  logic strobe_r;
  logic strobe_nxt;
  logic done_r;
  logic done_nxt;
  logic snoop_valid_r;
  logic snoop_valid_nxt;
  cap_addr_t snoop_addr_r;
  cap_addr_t snoop_addr_nxt;
  logic snoop_par_r;
  logic snoop_par_nxt;

  // =====================================================
  // Cycle issue and snoop capture
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    par_nxt = par_r;
    strobe_nxt = 1'b0;
    done_nxt = 1'b0;
    snoop_valid_nxt = 1'b0;
    snoop_addr_nxt = snoop_addr_r;
    snoop_par_nxt = snoop_par_r;
    case (state_r)
      PST_IDLE: begin
        if (cyc_req_valid && !bus.cpu_addr_hold) begin
          addr_nxt = cyc_req_addr;
          par_nxt = cap_line_par(cyc_req_addr);
          strobe_nxt = 1'b1;
          state_nxt = PST_ADDR;
        end
      end
      PST_ADDR: begin
        state_nxt = PST_WAIT;
      end
      PST_WAIT: begin
        // Address and parity stay put until the cycle moves on
        if (bus.next_addr_req || bus.burst_ready) begin
          done_nxt = 1'b1;
          state_nxt = PST_IDLE;
        end
      end
      default: begin
        state_nxt = PST_IDLE;
      end
    endcase
    if (bus.ext_inquire_strobe) begin
      snoop_valid_nxt = 1'b1;
      snoop_addr_nxt = bus.addr;
      snoop_par_nxt = bus.line_addr_parity;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= PST_IDLE;
      addr_r <= '0;
      par_r <= 1'b0;
      strobe_r <= 1'b0;
      done_r <= 1'b0;
      snoop_valid_r <= 1'b0;
      snoop_addr_r <= '0;
      snoop_par_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      par_r <= par_nxt;
      strobe_r <= strobe_nxt;
      done_r <= done_nxt;
      snoop_valid_r <= snoop_valid_nxt;
      snoop_addr_r <= snoop_addr_nxt;
      snoop_par_r <= snoop_par_nxt;
    end
  end

  // =====================================================
  // Pins
  assign bus.proc_addr_o = addr_r;
  assign bus.proc_addr_oe = !bus.cpu_addr_hold;
  assign bus.proc_par_o = par_r;
  assign bus.proc_par_oe = !bus.cpu_addr_hold;
  assign bus.cpu_addr_strobe = strobe_r;
  assign bus.ctrl_addr_strobe_copy = strobe_r;
  assign bus.branch_trace_bits = BT_IDLE;
  assign bus.sram_addr = {bus.addr[SRAM_CPU_HI:ADDR_LO], SRAM_A0};

  assign cyc_req_ready = (state_r == PST_IDLE) && !bus.cpu_addr_hold;
  assign cyc_done = done_r;
  assign snoop_valid = snoop_valid_r;
  assign snoop_addr = snoop_addr_r;
  assign snoop_parity = snoop_par_r;

endmodule

// File: cpu_addr_hold_parity_tb.sv
`timescale 1ns/1ps
module cpu_addr_hold_parity_tb;
  import cap_pkg::*;
  typedef struct packed {cap_kind_e kind; cap_addr_t a; logic inq;} cap_row_s;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic hold_active;
  logic req_valid = 1'b0;
  cap_kind_e req_kind = KIND_INQUIRE;
  cap_addr_t req_addr = '0;
  logic [3:0] side_hold = 4'h0;
  logic cyc_next_addr = 1'b0;
  logic cyc_burst_ready = 1'b0;
  logic cyc_req_valid = 1'b0;
  cap_addr_t cyc_req_addr = '0;
  logic req_ready, req_done, cyc_valid, cyc_parity, cyc_req_ready, cyc_done, snoop_valid, snoop_parity;
  cap_addr_t cyc_addr, snoop_addr;
  int err_count = 0;
  int tests_run = 0;
  cap_row_s rows [4] = '{'{KIND_INQUIRE, 29'h1FFFFFFF, 1'b1}, '{KIND_BACKINV, 29'h00000004, 1'b1},
                         '{KIND_FLUSH, 29'h0AAA5553, 1'b0}, '{KIND_SYNC, 29'h10000000, 1'b0}};

  always #5 sys_clk = ~sys_clk;

  cap_if bus_if ();
  cap_ctrl_end u_cap_ctrl_end (.sys_clk, .resetn, .clk_en, .req_valid, .req_kind, .req_addr, .req_ready,
    .req_done, .snoop_wb_active(side_hold[0]), .repl_wb_active(side_hold[1]), .init_active(side_hold[2]),
    .selftest_active(side_hold[3]), .cyc_next_addr, .cyc_burst_ready, .cyc_valid, .cyc_addr, .cyc_parity,
    .hold_active, .bus(bus_if.ctrl));
  cap_proc_end u_cap_proc_end (.sys_clk, .resetn, .clk_en, .cyc_req_valid, .cyc_req_addr, .cyc_req_ready,
    .cyc_done, .snoop_valid, .snoop_addr, .snoop_parity, .bus(bus_if.proc));
  cap_assertions u_cap_assertions (.sys_clk, .resetn, .selftest_active(side_hold[3]),
    .cpu_addr_hold(bus_if.cpu_addr_hold), .mem_side_hold_mirror(bus_if.mem_side_hold_mirror),
    .ext_inquire_strobe(bus_if.ext_inquire_strobe), .cpu_addr_strobe(bus_if.cpu_addr_strobe),
    .ctrl_addr_strobe_copy(bus_if.ctrl_addr_strobe_copy), .branch_trace_bits(bus_if.branch_trace_bits),
    .sram_addr(bus_if.sram_addr), .addr(bus_if.addr), .line_addr_parity(bus_if.line_addr_parity),
    .proc_addr_oe(bus_if.proc_addr_oe), .proc_par_oe(bus_if.proc_par_oe), .ctrl_addr_oe(bus_if.ctrl_addr_oe),
    .ctrl_par_oe(bus_if.ctrl_par_oe));

  // =====================================================
  // Shared tasks
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic ctrl_op(input cap_row_s r);
    logic seen_inq;
    int n;
    seen_inq = 1'b0;
    n = 0;
    req_valid = 1'b1;
    req_kind = r.kind;
    req_addr = r.a;
    while (req_ready !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    tick();
    req_valid = 1'b0;
    chk("hold", bus_if.cpu_addr_hold, 1'b1);
    chk("bus_addr", bus_if.addr, r.a);
    chk("bus_par", bus_if.line_addr_parity, ^r.a[31:5]);
    n = 0;
    while (req_done !== 1'b1 && n < 20) begin
      tick();
      n++;
      if (snoop_valid === 1'b1) begin
        seen_inq = 1'b1;
        chk("snoop_addr", snoop_addr, r.a);
        chk("snoop_par", snoop_parity, ^r.a[31:5]);
      end
    end
    chk("inquire", seen_inq, r.inq);
    chk("req_done", req_done, 1'b1);
  endtask

  task automatic proc_op(input cap_addr_t a, input logic use_na);
    logic seen_cyc;
    int n;
    seen_cyc = 1'b0;
    n = 0;
    cyc_req_valid = 1'b1;
    cyc_req_addr = a;
    while (cyc_req_ready !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    tick();
    cyc_req_valid = 1'b0;
    chk("strobe", bus_if.ctrl_addr_strobe_copy, 1'b1);
    chk("sram", bus_if.sram_addr, {a[17:3], 1'b0});
    chk("proc_par", bus_if.line_addr_parity, ^a[31:5]);
    cyc_next_addr = use_na;
    cyc_burst_ready = !use_na;
    n = 0;
    while (cyc_done !== 1'b1 && n < 20) begin
      tick();
      n++;
      if (cyc_valid === 1'b1) begin
        seen_cyc = 1'b1;
        chk("cyc_addr", cyc_addr, a);
        chk("cyc_par", cyc_parity, ^a[31:5]);
      end
    end
    chk("cyc_done", cyc_done, 1'b1);
    chk("cyc_seen", seen_cyc, 1'b1);
    cyc_next_addr = 1'b0;
    cyc_burst_ready = 1'b0;
  endtask

  // =====================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    chk("rst_hold", bus_if.cpu_addr_hold, 1'b1);
    chk("rst_mirror", bus_if.mem_side_hold_mirror, 1'b1);
    resetn = 1'b1;
    tick();
    $display("reset checks done");
    for (int i = 0; i < 4; i++) begin
      ctrl_op(rows[i]);
      proc_op(rows[i].a, i[0]);
      $display("row %0d done", i);
    end
    // Clock enable low freezes both ends
    clk_en = 1'b0;
    req_valid = 1'b1;
    tick();
    tick();
    chk("frozen_hold", bus_if.cpu_addr_hold, 1'b0);
    clk_en = 1'b1;
    ctrl_op(rows[0]);
    $display("freeze done");
    // Held cycle waits for an open processor cycle
    cyc_req_valid = 1'b1;
    cyc_req_addr = rows[2].a;
    tick();
    cyc_req_valid = 1'b0;
    fork
      ctrl_op(rows[3]);
      begin
        tick();
        tick();
        chk("phase_hold", bus_if.cpu_addr_hold, 1'b0);
        chk("phase_par", bus_if.line_addr_parity, ^rows[2].a[31:5]);
        cyc_burst_ready = 1'b1;
        tick();
        cyc_burst_ready = 1'b0;
      end
    join
    $display("phase guard done");
    for (int i = 0; i < 4; i++) begin
      side_hold = 4'h1 << i;
      tick();
      cyc_req_valid = 1'b1;
      cyc_req_addr = rows[i].a;
      tick();
      chk("no_strobe", bus_if.cpu_addr_strobe, 1'b0);
      chk("refused", cyc_req_ready, 1'b0);
      tick();
      chk("side_hold", bus_if.cpu_addr_hold, 1'b1);
      chk("hold_active", hold_active, 1'b1);
      chk("mirror", bus_if.mem_side_hold_mirror, i != 3);
      chk("float", bus_if.proc_addr_oe, 1'b0);
      cyc_req_valid = 1'b0;
      side_hold = 4'h0;
      tick();
      tick();
      chk("hold_off", bus_if.cpu_addr_hold, 1'b0);
      $display("side hold %0d done", i);
    end
    // Reset in mid-request cancels the held cycle
    req_valid = 1'b1;
    req_kind = KIND_INQUIRE;
    req_addr = rows[0].a;
    tick();
    req_valid = 1'b0;
    tick();
    resetn = 1'b0;
    tick();
    chk("rst_mid_hold", bus_if.cpu_addr_hold, 1'b1);
    chk("rst_mid_mirror", bus_if.mem_side_hold_mirror, 1'b1);
    resetn = 1'b1;
    tick();
    chk("rst_rel_hold", bus_if.cpu_addr_hold, 1'b0);
    chk("rst_rel_inq", bus_if.ext_inquire_strobe, 1'b0);
    $display("mid reset done");
    complete_run();
  end

  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule
